// ===== common/paint_engine_defines.svh
// Constants for the ellipse, pattern and paint command engine.
// Function
// - Opcode bit eight selects ellipse direction.
// - Ellipse takes a, b, then X radius.
// - Current pointer unchanged after ellipse.
// - Pattern memory holds sixteen by sixteen dots.
// - Each pattern dot written one to sixteen times per axis, all to the same pixel.
// - Paint fills region bounded by edge colour.
// - Paint is solid with colour one when colours are equal or the pattern is uniform, else with the colour of the pattern dot at the held prow_q, pcol_q.
// - Unreached region pushes X, Y, pattern pointer.
// - Bit E selects equal or differing boundary.
// - Only one display window is provided.
// - Copy takes two parameter words, then finishes with no pixel moved.
`ifndef PAINT_ENGINE_DEFINES_SVH
`define PAINT_ENGINE_DEFINES_SVH
`define OPC_ELLIPSE 6'h2B
`define OPC_PATTERN_DRAW 4'hF
`define OPC_PATTERN_WRITE 6'h06
`define OPC_PAINT 6'h32
`define OPC_ABS_MOVE 6'h20
`define OPC_WRITE_PARAM 4'h1
`define OPC_COPY 4'h6
`define OPC_SCAN_COPY 4'h7
`define OPC_HI 15
`define OPC_LO 10
`define DIR_BIT 8
`define EDGE_MODE_BIT 9
`define MAG_X_LO 0
`define MAG_Y_LO 4
`define PARAM_CL0 4'h0
`define PARAM_CL1 4'h1
`define PARAM_EDGE 4'h3
`define PARAM_PTR 4'h5
`define PATTERN_ROWS 16
`define SEED_WORDS 2'h3
`define WORD_ZERO 16'h0000
`define WORD_ONES 16'hFFFF
`endif

// ===== common/paint_engine_pkg.sv
// Types for the ellipse, pattern and paint command engine.
package paint_engine_pkg;
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_PARAM = 8'h02,
		ST_ELLIPSE = 8'h04,
		ST_PATTERN = 8'h08,
		ST_PAINT = 8'h10,
		ST_SEED = 8'h20,
		ST_COPY = 8'h40,
		ST_DONE = 8'h80
	} engine_state_type;
	typedef enum logic [2:0] {
		CMD_NONE = 3'h0,
		CMD_ELLIPSE = 3'h1,
		CMD_PATTERN = 3'h2,
		CMD_PATWRITE = 3'h3,
		CMD_PAINT = 3'h4,
		CMD_MOVE = 3'h5,
		CMD_WPARAM = 3'h6,
		CMD_COPY = 3'h7
	} command_type;
endpackage

// ===== core/paint_engine.sv
// Command engine for ellipse, pattern draw and paint operations.
`timescale 1ns/1ps
`include "paint_engine_defines.svh"
module paint_engine #(
	parameter int COORD_W = 16,
	parameter int SPAN_MAX = 1024
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// Command FIFO read side.
	input wire logic cmd_valid_in,
	input wire logic [15:0] cmd_data_in,
	output logic cmd_ready_out,
	// Read FIFO write side.
	output logic rfifo_valid_out,
	output logic [15:0] rfifo_data_out,
	input wire logic rfifo_ready_in,
	// Frame buffer pixel port.
	output logic pix_wr_out,
	output logic pix_rd_out,
	output logic [COORD_W-1:0] pix_x_out,
	output logic [COORD_W-1:0] pix_y_out,
	output logic [15:0] pix_color_out,
	input wire logic [15:0] pix_rd_data_in,
	// Status.
	output logic busy_out,
	output logic ellipse_cw_out,
	output logic [15:0] cur_x_out,
	output logic [15:0] cur_y_out,
	output logic window_count_out,
	// Register port.
	input wire logic [3:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [15:0] reg_rdata_out
);
	import paint_engine_pkg::*;
	initial begin
		if (COORD_W != 16) $error("coordinates must be 16 bits");
		if (SPAN_MAX < 2) $error("span limit too small");
	end
	// ----------------------------------------
	// Registers and decode
	// ----------------------------------------
	engine_state_type state_q, state_d;
	command_type cmd_q;
	logic [15:0] color_reg_zero_q, color_reg_one_q, edge_color_reg_q;
	logic [15:0] pattern_pointer_reg_q;
	logic [15:0] current_x_q, current_y_q;
	logic [15:0] opcode_q;
	logic [15:0] par_q [3];
	logic [1:0] par_cnt_q, par_need;
	logic [4:0] pat_rows_q;
	logic [3:0] pat_wrow_q;
	logic [15:0] cx_q, cy_q;
	logic [3:0] prow_q, pcol_q, rep_x_q, rep_y_q;
	logic [15:0] seed_x_q, seed_y_q;
	logic [1:0] seed_idx_q;
	logic seen_q, dir_q, step_q;
	logic [31:0] err_q;
	logic [15:0] ex_q, ey_q;
	logic [9:0] span_q;
	logic rd_pend_q;
	command_type dec_cmd;
	logic cmd_take, par_take, pat_bit, pat_uniform;
	logic boundary_hit, wpar_take, pat_wr;
	logic [3:0] mag_x, mag_y;
	function automatic command_type decode(input logic [15:0] w);
		logic [5:0] h;
		h = w[`OPC_HI:`OPC_LO];
		if (h == `OPC_ELLIPSE) decode = CMD_ELLIPSE;
		else if (w[15:12] == `OPC_PATTERN_DRAW) decode = CMD_PATTERN;
		else if (h == `OPC_PATTERN_WRITE) decode = CMD_PATWRITE;
		else if (h == `OPC_PAINT) decode = CMD_PAINT;
		else if (h == `OPC_ABS_MOVE) decode = CMD_MOVE;
		else if (w[15:12] == `OPC_WRITE_PARAM) decode = CMD_WPARAM;
		else if (w[15:12] == `OPC_COPY || w[15:12] == `OPC_SCAN_COPY)
			decode = CMD_COPY;
		else decode = CMD_NONE;
	endfunction
	function automatic logic [1:0] params_of(input command_type c);
		case (c)
			CMD_ELLIPSE: params_of = 2'h3;
			CMD_PATWRITE: params_of = 2'h1;
			CMD_MOVE: params_of = 2'h2;
			CMD_WPARAM: params_of = 2'h1;
			CMD_COPY: params_of = 2'h2;
			default: params_of = 2'h0;
		endcase
	endfunction
	assign dec_cmd = decode(cmd_data_in);
	assign cmd_ready_out = (state_q == ST_IDLE) || (state_q == ST_PARAM)
		|| (state_q == ST_PATTERN && cmd_q == CMD_PATWRITE);
	assign cmd_take = cmd_valid_in && cmd_ready_out && state_q == ST_IDLE;
	assign par_take = cmd_valid_in && state_q == ST_PARAM;
	assign par_need = params_of(cmd_q);
	assign mag_x = opcode_q[`MAG_X_LO +: 4];
	assign mag_y = opcode_q[`MAG_Y_LO +: 4];
	assign pat_wr = (state_q == ST_PATTERN) && cmd_q == CMD_PATWRITE
		&& cmd_valid_in;
	assign wpar_take = par_take && cmd_q == CMD_WPARAM;
	assign boundary_hit = opcode_q[`EDGE_MODE_BIT]
		? (pix_rd_data_in != edge_color_reg_q)
		: (pix_rd_data_in == edge_color_reg_q);
	pattern_memory #(.ROWS(`PATTERN_ROWS)) u_pmem (
		.sys_clk_in(sys_clk_in),
		.wr_en_in(pat_wr),
		.wr_row_in(pat_wrow_q),
		.wr_data_in(cmd_data_in),
		.rd_row_in(prow_q),
		.rd_col_in(pcol_q),
		.rd_bit_out(pat_bit),
		.uniform_out(pat_uniform)
	);
	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (cmd_take) begin
					if (params_of(dec_cmd) != 2'h0) state_d = ST_PARAM;
					else if (dec_cmd == CMD_PATTERN) state_d = ST_PATTERN;
					else if (dec_cmd == CMD_PAINT) state_d = ST_PAINT;
				end
			end
			ST_PARAM: begin
				if (par_take && par_cnt_q == par_need - 2'h1) begin
					if (cmd_q == CMD_ELLIPSE) state_d = ST_ELLIPSE;
					else if (cmd_q == CMD_PATWRITE
						&& cmd_data_in[4:0] != 5'h00) state_d = ST_PATTERN;
					else if (cmd_q == CMD_COPY) state_d = ST_COPY;
					else state_d = ST_IDLE;
				end
			end
			ST_ELLIPSE: if (step_q && ey_q == 16'h0000) state_d = ST_DONE;
			ST_PATTERN: begin
				if (cmd_q == CMD_PATWRITE) begin
					if (pat_wr && pat_rows_q == 5'h01) state_d = ST_IDLE;
				end else if (prow_q == 4'hF && pcol_q == 4'h0
					&& rep_x_q == 4'h0 && rep_y_q == 4'h0) begin
					state_d = ST_DONE;
				end
			end
			ST_PAINT: begin
				if (rd_pend_q && boundary_hit) begin
					if (seen_q) state_d = ST_SEED;
					else state_d = ST_DONE;
				end else if (span_q == 10'(SPAN_MAX - 1)) state_d = ST_DONE;
			end
			ST_SEED: begin
				if (rfifo_ready_in && seed_idx_q == 2'h2) state_d = ST_DONE;
			end
			ST_COPY: state_d = ST_DONE;
			ST_DONE: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) state_q <= ST_IDLE;
		else state_q <= state_d;
	end
	// ----------------------------------------
	// Command capture and drawing parameters
	// ----------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			cmd_q <= CMD_NONE;
			opcode_q <= 16'h0000;
			par_cnt_q <= 2'h0;
			pat_rows_q <= 5'h00;
			pat_wrow_q <= 4'h0;
		end else begin
			if (cmd_take) begin
				cmd_q <= dec_cmd;
				opcode_q <= cmd_data_in;
				par_cnt_q <= 2'h0;
			end
			if (par_take) begin
				par_q[par_cnt_q] <= cmd_data_in;
				par_cnt_q <= par_cnt_q + 2'h1;
				if (cmd_q == CMD_PATWRITE) begin
					pat_rows_q <= (cmd_data_in[4:0] > 5'h10)
						? 5'h10 : cmd_data_in[4:0];
					pat_wrow_q <= 4'h0;
				end
			end
			if (pat_wr) begin
				pat_wrow_q <= pat_wrow_q + 4'h1;
				pat_rows_q <= pat_rows_q - 5'h01;
			end
		end
	end
	// Parameter writes take the low nibble of the opcode as index.
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			color_reg_zero_q <= 16'h0000;
			color_reg_one_q <= 16'h0000;
			edge_color_reg_q <= 16'h0000;
			pattern_pointer_reg_q <= 16'h0000;
		end else if (wpar_take || reg_wr_in) begin
			case (reg_wr_in ? reg_addr_in : opcode_q[3:0])
				`PARAM_CL0: color_reg_zero_q <= reg_wr_in ? reg_wdata_in
					: cmd_data_in;
				`PARAM_CL1: color_reg_one_q <= reg_wr_in ? reg_wdata_in
					: cmd_data_in;
				`PARAM_EDGE: edge_color_reg_q <= reg_wr_in ? reg_wdata_in
					: cmd_data_in;
				`PARAM_PTR: pattern_pointer_reg_q <= reg_wr_in
					? reg_wdata_in : cmd_data_in;
				default: ;
			endcase
		end
	end
	// ----------------------------------------
	// Current pointer and drawing walk
	// ----------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			current_x_q <= 16'h0000;
			current_y_q <= 16'h0000;
		end else if (par_take && cmd_q == CMD_MOVE) begin
			if (par_cnt_q == 2'h0) current_x_q <= cmd_data_in;
			else current_y_q <= cmd_data_in;
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			ex_q <= 16'h0000;
			ey_q <= 16'h0000;
			err_q <= 32'h0;
			step_q <= 1'b0;
			dir_q <= 1'b0;
		end else if (state_q == ST_PARAM && state_d == ST_ELLIPSE) begin
			ex_q <= cmd_data_in;
			ey_q <= cmd_data_in;
			err_q <= 32'h0;
			step_q <= 1'b0;
			dir_q <= opcode_q[`DIR_BIT];
		end else if (state_q == ST_ELLIPSE) begin
			step_q <= 1'b1;
			// Trades exact conic accuracy for one multiply per step.
			if (err_q[31]) begin
				err_q <= err_q + 32'(par_q[1] * ex_q);
				ex_q <= ex_q - 16'h0001;
			end else begin
				err_q <= err_q - 32'(par_q[0] * ey_q);
				ey_q <= (ey_q == 16'h0000) ? 16'h0000 : ey_q - 16'h0001;
			end
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			prow_q <= 4'h0;
			pcol_q <= 4'h0;
			rep_x_q <= 4'h0;
			rep_y_q <= 4'h0;
		end else if (cmd_take && dec_cmd == CMD_PATTERN) begin
			prow_q <= 4'h0;
			pcol_q <= 4'hF;
			rep_x_q <= cmd_data_in[`MAG_X_LO +: 4];
			rep_y_q <= cmd_data_in[`MAG_Y_LO +: 4];
		end else if (state_q == ST_PATTERN && cmd_q == CMD_PATTERN) begin
			if (rep_x_q != 4'h0) rep_x_q <= rep_x_q - 4'h1;
			else if (pcol_q != 4'h0) begin
				pcol_q <= pcol_q - 4'h1;
				rep_x_q <= mag_x;
			end else if (rep_y_q != 4'h0) begin
				pcol_q <= 4'hF;
				rep_x_q <= mag_x;
				rep_y_q <= rep_y_q - 4'h1;
			end else begin
				prow_q <= prow_q + 4'h1;
				pcol_q <= 4'hF;
				rep_x_q <= mag_x;
				rep_y_q <= mag_y;
			end
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			span_q <= 10'h000;
			rd_pend_q <= 1'b0;
			seen_q <= 1'b0;
			seed_x_q <= 16'h0000;
			seed_y_q <= 16'h0000;
			seed_idx_q <= 2'h0;
		end else if (cmd_take && dec_cmd == CMD_PAINT) begin
			span_q <= 10'h000;
			rd_pend_q <= 1'b0;
			seen_q <= 1'b0;
			seed_idx_q <= 2'h0;
		end else if (state_q == ST_PAINT) begin
			rd_pend_q <= ~rd_pend_q;
			if (rd_pend_q) begin
				span_q <= span_q + 10'h001;
				// The row below is never read, so any filled span that stops at the boundary seeds it.
				seen_q <= 1'b1;
				seed_x_q <= current_x_q + 16'(span_q);
				seed_y_q <= current_y_q - 16'h0001;
			end
		end else if (state_q == ST_SEED && rfifo_ready_in) begin
			seed_idx_q <= seed_idx_q + 2'h1;
		end
	end
	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	logic [15:0] fill_color;
	assign fill_color = (color_reg_zero_q == color_reg_one_q || pat_uniform)
		? color_reg_one_q : (pat_bit ? color_reg_one_q : color_reg_zero_q);
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			pix_wr_out <= 1'b0;
			pix_rd_out <= 1'b0;
			pix_x_out <= '0;
			pix_y_out <= '0;
			pix_color_out <= 16'h0000;
			reg_rdata_out <= 16'h0000;
		end else begin
			pix_rd_out <= state_q == ST_PAINT && !rd_pend_q;
			pix_wr_out <= state_q == ST_ELLIPSE || (state_q == ST_PAINT
				&& rd_pend_q && !boundary_hit)
				|| (state_q == ST_PATTERN && cmd_q == CMD_PATTERN);
			if (state_q == ST_ELLIPSE) begin
				pix_x_out <= dir_q ? current_x_q + ex_q : current_x_q - ex_q;
				pix_y_out <= current_y_q + ey_q;
				pix_color_out <= color_reg_one_q;
			end else if (state_q == ST_PAINT) begin
				pix_x_out <= current_x_q + 16'(span_q);
				pix_y_out <= current_y_q;
				pix_color_out <= fill_color;
			end else begin
				pix_x_out <= current_x_q + 16'(4'hF - pcol_q);
				pix_y_out <= current_y_q - 16'(prow_q);
				pix_color_out <= pat_bit ? color_reg_one_q : color_reg_zero_q;
			end
			if (reg_rd_in) begin
				case (reg_addr_in)
					`PARAM_CL0: reg_rdata_out <= color_reg_zero_q;
					`PARAM_CL1: reg_rdata_out <= color_reg_one_q;
					`PARAM_EDGE: reg_rdata_out <= edge_color_reg_q;
					`PARAM_PTR: reg_rdata_out <= pattern_pointer_reg_q;
					default: reg_rdata_out <= 16'h0000;
				endcase
			end
		end
	end
	assign rfifo_valid_out = state_q == ST_SEED;
	assign rfifo_data_out = (seed_idx_q == 2'h0) ? seed_x_q
		: (seed_idx_q == 2'h1) ? seed_y_q : pattern_pointer_reg_q;
	assign busy_out = state_q != ST_IDLE;
	assign ellipse_cw_out = dir_q;
	assign cur_x_out = current_x_q;
	assign cur_y_out = current_y_q;
	assign window_count_out = 1'b1;
endmodule

// ===== core/pattern_memory.sv
// Sixteen-row pattern memory with word write and bit read.
`timescale 1ns/1ps
`include "paint_engine_defines.svh"
module pattern_memory #(
	parameter int ROWS = `PATTERN_ROWS
) (
	input wire logic sys_clk_in,
	input wire logic wr_en_in,
	input wire logic [3:0] wr_row_in,
	input wire logic [15:0] wr_data_in,
	input wire logic [3:0] rd_row_in,
	input wire logic [3:0] rd_col_in,
	output logic rd_bit_out,
	output logic uniform_out
);
	logic [15:0] mem_q [ROWS];
	logic [ROWS-1:0] row_ones;
	logic [ROWS-1:0] row_zero;
	initial begin
		if (ROWS != 16) $error("pattern memory must have 16 rows");
	end
	always_ff @(posedge sys_clk_in) begin
		if (wr_en_in) mem_q[wr_row_in] <= wr_data_in;
	end
	genvar g;
	generate
		for (g = 0; g < ROWS; g++) begin : g_row
			assign row_ones[g] = (mem_q[g] == `WORD_ONES);
			assign row_zero[g] = (mem_q[g] == `WORD_ZERO);
		end
	endgenerate
	assign rd_bit_out = mem_q[rd_row_in][4'hF - rd_col_in];
	assign uniform_out = (&row_ones) | (&row_zero);
endmodule

// ===== verif/frame_buffer_model.sv
// Frame buffer model answering pixel reads around a bounded span.
`timescale 1ns/1ps
module frame_buffer_model #(
	parameter int LO = 10,
	parameter int HI = 30
) (
	input wire logic pix_rd_in,
	input wire logic [15:0] pix_x_in,
	input wire logic [15:0] inside_in,
	input wire logic [15:0] outside_in,
	output logic [15:0] pix_data_out
);
	// region colour inside, boundary colour outside.
	// The engine samples in the read cycle itself, so the answer is direct.
	// Between reads the inverse shows, so stale values never look valid.
	always_comb begin
		if (pix_rd_in)
			pix_data_out = (pix_x_in >= LO && pix_x_in <= HI) ?
				inside_in : outside_in;
		else
			pix_data_out = ~inside_in;
	end
endmodule

// ===== verif/paint_engine_chk.sv
// Checker for the paint engine ports.
`timescale 1ns/1ps
module paint_engine_chk (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic cmd_valid_in,
	input wire logic [15:0] cmd_data_in,
	input wire logic cmd_ready_out,
	input wire logic rfifo_valid_out,
	input wire logic [15:0] rfifo_data_out,
	input wire logic rfifo_ready_in,
	input wire logic pix_wr_out,
	input wire logic [15:0] pix_color_out,
	input wire logic busy_out,
	input wire logic ellipse_cw_out,
	input wire logic [15:0] cur_x_out,
	input wire logic [15:0] cur_y_out,
	input wire logic window_count_out,
	input wire logic [3:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [15:0] reg_rdata_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	// Opcodes are only taken while idle; later words are parameters.
	wire op_take = cmd_valid_in && cmd_ready_out && !busy_out;
	wire [5:0] opc = cmd_data_in[15:10];
	logic [15:0] cl0_q, cl1_q, sx_q, sy_q;
	logic [7:0] push_q;
	logic dir_q, seen_q, ell_q, draw_q;
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			{cl0_q, cl1_q, sx_q, sy_q, push_q} <= '0;
			{dir_q, seen_q, ell_q, draw_q} <= '0;
		end else begin
			if (reg_wr_in && reg_addr_in == 4'h0) cl0_q <= reg_wdata_in;
			if (reg_wr_in && reg_addr_in == 4'h1) cl1_q <= reg_wdata_in;
			if (op_take) begin
				ell_q <= opc == 6'h2B;
				draw_q <= opc == 6'h32 || cmd_data_in[15:12] == 4'hF;
				push_q <= 8'h00;
			end else if (rfifo_valid_out && rfifo_ready_in) begin
				push_q <= push_q + 8'h01;
			end
			if (op_take && opc == 6'h2B) begin
				dir_q <= cmd_data_in[8];
				seen_q <= 1'b1;
				sx_q <= cur_x_out;
				sy_q <= cur_y_out;
			end
		end
	end
	property p_window; window_count_out == 1'b1; endproperty
	a_window: assert property (p_window)
		else $error("more than one window reported");
	property p_dir; seen_q && !busy_out |-> ellipse_cw_out == dir_q;
	endproperty
	a_dir: assert property (p_dir)
		else $error("ellipse direction differs from opcode bit");
	property p_center; ell_q && $fell(busy_out) |->
		cur_x_out == sx_q && cur_y_out == sy_q; endproperty
	a_center: assert property (p_center)
		else $error("pointer moved by ellipse");
	property p_seed_hold; rfifo_valid_out && !rfifo_ready_in |=>
		rfifo_valid_out && $stable(rfifo_data_out); endproperty
	a_seed_hold: assert property (p_seed_hold)
		else $error("seed word dropped before accepted");
	property p_seed_triple; $fell(busy_out) |-> push_q % 3 == 0;
	endproperty
	a_seed_triple: assert property (p_seed_triple)
		else $error("seed words not in groups of three");
	property p_pat_color; pix_wr_out && draw_q |->
		pix_color_out == cl0_q || pix_color_out == cl1_q; endproperty
	a_pat_color: assert property (p_pat_color)
		else $error("drawn colour not a colour register");
	property p_solid; pix_wr_out && draw_q && cl0_q == cl1_q |->
		pix_color_out == cl0_q; endproperty
	a_solid: assert property (p_solid)
		else $error("fill not solid with equal colours");
	property p_rd_cl0; reg_rd_in && reg_addr_in == 4'h0 |=>
		reg_rdata_out == cl0_q; endproperty
	a_rd_cl0: assert property (p_rd_cl0)
		else $error("colour zero read back wrong");
endmodule
bind paint_engine paint_engine_chk i_chk (.sys_clk_in, .rst_in,
	.cmd_valid_in, .cmd_data_in, .cmd_ready_out, .rfifo_valid_out,
	.rfifo_data_out, .rfifo_ready_in, .pix_wr_out, .pix_color_out,
	.busy_out, .ellipse_cw_out, .cur_x_out, .cur_y_out, .window_count_out,
	.reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out);

// ===== verif/testbench.sv
// Self-checking testbench for the paint engine.
`timescale 1ns/1ps
module testbench;
	import paint_engine_pkg::*;
	logic sys_clk_in = 0, rst_in = 1, cmd_valid_in = 0, rfifo_ready_in = 0;
	logic reg_wr_in = 0, reg_rd_in = 0, paint_on = 0;
	logic [15:0] cmd_data_in = 16'h0000, reg_wdata_in = 16'h0000;
	logic [15:0] in_c = 16'h0000, out_c = 16'h0000, cl1v = 16'h2222;
	logic [15:0] pix_rd_data_in, rfifo_data_out, pix_x_out, pix_y_out;
	logic [15:0] pix_color_out, cur_x_out, cur_y_out, reg_rdata_out;
	logic [3:0] reg_addr_in = 4'h0;
	logic [7:0] m;
	logic [7:0] mags [3] = '{8'h00, 8'h21, 8'h0F};
	logic cmd_ready_out, rfifo_valid_out, pix_wr_out, pix_rd_out, busy_out;
	logic ellipse_cw_out, window_count_out;
	int mismatches = 0, n_tests = 0, nwr, n1, nout;
	logic [15:0] seeds[$], q[$];
	frame_buffer_model i_fb (.pix_rd_in(pix_rd_out),
		.pix_x_in(pix_x_out), .inside_in(in_c), .outside_in(out_c),
		.pix_data_out(pix_rd_data_in));
	paint_engine #(.SPAN_MAX(64)) i_dut (.sys_clk_in, .rst_in, .cmd_valid_in,
		.cmd_data_in, .cmd_ready_out, .rfifo_valid_out, .rfifo_data_out,
		.rfifo_ready_in, .pix_wr_out, .pix_rd_out, .pix_x_out, .pix_y_out,
		.pix_color_out, .pix_rd_data_in, .busy_out, .ellipse_cw_out,
		.cur_x_out, .cur_y_out, .window_count_out, .reg_addr_in,
		.reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out);
	initial forever #12.5 sys_clk_in = ~sys_clk_in;
	always @(posedge sys_clk_in) begin
		if (pix_wr_out === 1'b1) begin
			nwr++;
			if (pix_color_out === cl1v) n1++;
			if (paint_on && (pix_x_out < 10 || pix_x_out > 30)) nout++;
		end
		if (rfifo_valid_out === 1'b1 && rfifo_ready_in === 1'b1)
			seeds.push_back(rfifo_data_out);
	end
	task check(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task conclude;
		if (mismatches == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk_in);
		reg_wr_in <= 1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge sys_clk_in);
		reg_wr_in <= 0;
	endtask
	task rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge sys_clk_in);
		reg_rd_in <= 1;
		reg_addr_in <= a;
		@(posedge sys_clk_in);
		reg_rd_in <= 0;
		#1 check(reg_rdata_out, e);
	endtask
	// Each word is held until the engine takes it.
	task cmd;
		@(posedge sys_clk_in);
		foreach (q[i]) begin
			cmd_valid_in <= 1;
			cmd_data_in <= q[i];
			do @(posedge sys_clk_in); while (cmd_ready_out !== 1'b1);
		end
		cmd_valid_in <= 0;
	endtask
	task idle;
		repeat (3) @(posedge sys_clk_in);
		while (busy_out !== 1'b0) @(posedge sys_clk_in);
	endtask
	initial begin
		repeat (60000) @(posedge sys_clk_in);
		mismatches++;
		conclude;
	end
	initial begin
		repeat (12) @(posedge sys_clk_in);
		rst_in <= 0;
		check(window_count_out, 1);
		wr(4'h0, 16'h1111);
		wr(4'h1, 16'h2222);
		wr(4'h3, 16'h00F0);
		rd(4'h0, 16'h1111);
		rd(4'h1, 16'h2222);
		rd(4'h3, 16'h00F0);
		rd(4'hF, 16'h0000);
		q = {16'h1005, 16'h0456};
		cmd;
		idle;
		rd(4'h5, 16'h0456);
		q = {16'h1800, 16'd16};
		repeat (16) q.push_back(16'h00FF);
		cmd;
		idle;
		q = {16'h8000, 16'd20, 16'd5};
		cmd;
		idle;
		check(cur_x_out, 16'd20);
		foreach (mags[k]) begin
			m = mags[k];
			nwr = 0;
			n1 = 0;
			q = {{8'hF0, m}};
			cmd;
			idle;
			check(nwr, 256 * (m[3:0] + 1) * (m[7:4] + 1));
			check(n1, 128 * (m[3:0] + 1) * (m[7:4] + 1));
		end
		for (int d = 0; d < 2; d++) begin
			q = {16'hAC00 | 16'(d << 8), 16'd25, 16'd9, 16'd10};
			cmd;
			idle;
			check(ellipse_cw_out, d);
			check(cur_x_out, 16'd20);
			check(cur_y_out, 16'd5);
		end
		q = {16'h6000, 16'd3, 16'd4, 16'h8000, 16'd20, 16'd6};
		cmd;
		idle;
		check(cur_y_out, 16'd6);
		for (int e = 0; e < 2; e++) begin
			in_c = e ? 16'h00F0 : 16'h0000;
			out_c = e ? 16'h0055 : 16'h00F0;
			if (e) cl1v = 16'h1111;
			wr(4'h1, cl1v);
			wr(4'h5, 16'h0123);
			seeds.delete();
			nwr = 0;
			n1 = 0;
			nout = 0;
			paint_on = 1;
			q = {16'hC800 | 16'(e << 9)};
			cmd;
			repeat (3) @(posedge sys_clk_in);
			while (busy_out !== 1'b0 && rfifo_valid_out !== 1'b1)
				@(posedge sys_clk_in);
			repeat (5) @(posedge sys_clk_in);
			rfifo_ready_in <= 1;
			idle;
			rfifo_ready_in <= 0;
			paint_on = 0;
			check(nout, 0);
			check(nwr > 0, 1);
			if (e) check(n1, nwr);
			check(seeds.size() % 3, 0);
			if (seeds.size() >= 3) check(seeds[2], 16'h0123);
		end
		conclude;
	end
endmodule
